/* hpha_host_model.sv */
module hpha_host_model
    import hpha_pkg::*;
(
    // clock and straps
    input wire logic clk_sys,
    input wire logic bus_style_sel,
    input wire logic out_edge_sel,
    // handshake pin
    input wire logic hs_o,
    input wire logic hs_oe,
    // host bus
    output hpha_pkg::hpha_bus_t bus
);
    // ------------------------------
    // host accesses
    // ------------------------------
    initial bus = '{cs_n: 1'b1, default: '0};
    task automatic par(input logic w, input logic [7:0] a, input logic keep);
        int n;
        if (bus.cs_n)
        begin
            bus.ad <= a;
            bus.ale <= 1'b1;
            @(negedge clk_sys);
            bus.ale <= 1'b0;
            @(negedge clk_sys);
        end
        bus.cs_n <= 1'b0;
        bus.rd <= !w;
        bus.wr <= w;
        for (n = 0; n < 20 && !(hs_oe && hs_o == bus_style_sel); n++)
            @(negedge clk_sys);
        // a kept access holds one more cycle so the standing answer is seen
        if (keep)
            @(negedge clk_sys);
        bus.rd <= 1'b0;
        bus.wr <= 1'b0;
        bus.cs_n <= !keep;
        repeat (3) @(negedge clk_sys);
    endtask
    task automatic ser(input logic r, input logic [6:0] a, output logic [7:0] q,
        output logic oe);
        logic [15:0] f;
        f = {1'b1, a, a, r};
        q = 8'h00;
        oe = 1'b0;
        bus.cs_n <= 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            repeat (2) @(negedge clk_sys);
            bus.sdi <= f[i];
            repeat (2) @(negedge clk_sys);
            if (i > 7 && out_edge_sel)
                q[i-8] = hs_o;
            bus.sclk <= 1'b1;
            repeat (4) @(negedge clk_sys);
            if (i > 7 && !out_edge_sel)
                q[i-8] = hs_o;
            oe = oe | hs_oe;
            bus.sclk <= 1'b0;
        end
        repeat (2) @(negedge clk_sys);
        bus.cs_n <= 1'b1;
        repeat (3) @(negedge clk_sys);
    endtask
endmodule

/* hpha_irq.sv */
module hpha_irq
    import hpha_pkg::*;
#(
    parameter int NSRC = HPHA_NSRC
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // sources
    input wire logic [NSRC-1:0] src_event,
    input wire logic [NSRC-1:0] src_enable,
    input wire logic [NSRC-1:0] src_clear,
    // status
    output logic [NSRC-1:0] pending,
    output logic irq_active
);
    // ----------------------------------------
    // sticky pending, set wins over clear
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NSRC; g++)
        begin : g_src
            always_ff @(posedge clk_sys)
            begin
                if (!resetn)
                    pending[g] <= 1'b0;
                else if (src_event[g])
                    pending[g] <= 1'b1;
                else if (src_clear[g])
                    pending[g] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            irq_active <= 1'b0;
        else
            irq_active <= |(pending & src_enable);
    end
endmodule

/* hpha_pkg.sv */
package hpha_pkg;
    // ----------------------------------------
    // bus modes and constants
    // ----------------------------------------
    localparam int HPHA_NSRC = 8;
    localparam logic HPHA_STYLE_STROBE = 1'b0;
    localparam logic HPHA_STYLE_RWEN = 1'b1;
    localparam logic [1:0] HPHA_MODE_PAR = 2'h0;
    localparam logic [1:0] HPHA_MODE_SER = 2'h1;
    localparam logic [3:0] HPHA_WAIT_CYC = 4'h2;
    localparam logic [3:0] HPHA_ACC_CYC = 4'h1;
    localparam logic [7:0] HPHA_ADDR_RST = 8'h00;

    // strobes from the host, already sampled
    typedef struct packed {
        logic cs_n;
        logic rd;
        logic wr;
        logic ale;
        logic sclk;
        logic sdi;
        logic [7:0] ad;
    } hpha_bus_t;

    // open-drain / tristate pin pair, output side
    typedef struct packed {
        logic o;
        logic oe;
    } hpha_pin_t;

    typedef enum logic [1:0] {
        HPHA_IDLE = 2'b00,
        HPHA_WAIT = 2'b01,
        HPHA_DONE = 2'b11,
        HPHA_HOLD = 2'b10
    } hpha_state_t;
endpackage

/* hpha_ser.sv */
module hpha_ser
    import hpha_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // serial host pins
    input wire logic ser_en,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic out_edge_sel,
    // read data to shift out
    input wire logic [7:0] rd_data,
    // pin drive
    output logic ser_o,
    output logic ser_oe
);
    // ----------------------------------------
    // serial shifter: bit0 r/w, 7 addr, 8 data
    // ----------------------------------------
    logic sclk_r;
    logic [4:0] cnt_r;
    logic is_read_r;
    logic [7:0] sh_r;
    logic rise;
    logic fall;
    logic upd;

    assign rise = sclk & ~sclk_r;
    assign fall = ~sclk & sclk_r;
    // update on the opposite edge so data is stable on the selected one
    assign upd = out_edge_sel ? fall : rise;

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            sclk_r <= 1'b0;
        else
            sclk_r <= sclk;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn || cs_n || !ser_en)
        begin
            cnt_r <= 5'h00;
            is_read_r <= 1'b0;
        end
        else if (rise && cnt_r != 5'h10)
        begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == 5'h00)
                is_read_r <= sdi;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            sh_r <= 8'h00;
            ser_o <= 1'b0;
            ser_oe <= 1'b0;
        end
        else if (cs_n || !ser_en || !is_read_r)
        begin
            sh_r <= rd_data;
            ser_o <= 1'b0;
            ser_oe <= 1'b0;
        end
        else if (upd && cnt_r >= 5'h08)
        begin
            ser_o <= sh_r[0];
            sh_r <= {1'b0, sh_r[7:1]};
            ser_oe <= 1'b1;
        end
    end
endmodule

/* hpha_top.sv */
module hpha_top
    import hpha_pkg::*;
#(
    parameter int NSRC = HPHA_NSRC,
    parameter logic [3:0] WAIT_CYC = HPHA_WAIT_CYC,
    parameter logic [3:0] ACC_CYC = HPHA_ACC_CYC
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // mode straps
    input wire logic bus_style_sel,
    input wire logic [1:0] port_mode,
    input wire logic out_edge_sel,
    // host bus, sampled
    input wire hpha_pkg::hpha_bus_t host_bus,
    // interrupt sources and read data
    input wire logic [NSRC-1:0] src_event,
    input wire logic [NSRC-1:0] src_enable,
    input wire logic [NSRC-1:0] src_clear,
    input wire logic [7:0] rd_data,
    // register-side access
    output logic [7:0] acc_addr,
    output logic acc_rd,
    output logic acc_wr,
    // interrupt pin
    output logic irq_n_o,
    output logic irq_n_oe,
    // acknowledge / ready / serial pin
    output logic hs_o,
    output logic hs_oe
);
    import hpha_pkg::*;

    // ----------------------------------------
    // interrupt
    // ----------------------------------------
    logic irq_active;
    logic [NSRC-1:0] pending;

    hpha_irq #(.NSRC(NSRC)) u_irq (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .src_event(src_event),
        .src_enable(src_enable),
        .src_clear(src_clear),
        .pending(pending),
        .irq_active(irq_active)
    );

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            irq_n_o <= 1'b0;
            irq_n_oe <= 1'b0;
        end
        else
        begin
            irq_n_o <= 1'b0;
            irq_n_oe <= irq_active;
        end
    end

    // ----------------------------------------
    // serial port
    // ----------------------------------------
    logic ser_en;
    logic ser_o;
    logic ser_oe;

    assign ser_en = (port_mode == HPHA_MODE_SER);

    hpha_ser u_ser (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ser_en(ser_en),
        .cs_n(host_bus.cs_n),
        .sclk(host_bus.sclk),
        .sdi(host_bus.sdi),
        .out_edge_sel(out_edge_sel),
        .rd_data(rd_data),
        .ser_o(ser_o),
        .ser_oe(ser_oe)
    );

    // ----------------------------------------
    // address latch
    // ----------------------------------------
    logic ale_r;
    logic style_r;

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            ale_r <= 1'b0;
        else
            ale_r <= host_bus.ale;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            acc_addr <= HPHA_ADDR_RST;
        else if (!ser_en && ale_r && !host_bus.ale)
            acc_addr <= host_bus.ad;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            style_r <= HPHA_STYLE_STROBE;
        else
            style_r <= bus_style_sel;
    end

    // ----------------------------------------
    // parallel handshake
    // ----------------------------------------
    hpha_state_t st_r;
    hpha_state_t st_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic prev_r;
    logic prev_nxt;
    logic is_wr;
    logic is_rd;
    logic par_go;

    assign is_wr = host_bus.wr;
    assign is_rd = host_bus.rd;
    assign par_go = !ser_en && !host_bus.cs_n && (is_wr || is_rd);

    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        prev_nxt = prev_r;
        case (st_r)
            HPHA_IDLE:
            begin
                if (par_go)
                begin
                    st_nxt = HPHA_WAIT;
                    if (style_r == HPHA_STYLE_STROBE)
                        cnt_nxt = (is_wr && prev_r) ? WAIT_CYC : 4'h0;
                    else
                        cnt_nxt = ACC_CYC;
                end
                else if (host_bus.cs_n)
                    prev_nxt = 1'b0;
            end
            HPHA_WAIT:
            begin
                if (host_bus.cs_n)
                    st_nxt = HPHA_IDLE;
                else if (cnt_r == 4'h0)
                    st_nxt = HPHA_DONE;
                else
                    cnt_nxt = cnt_r - 4'h1;
            end
            HPHA_DONE:
            begin
                st_nxt = HPHA_HOLD;
                prev_nxt = 1'b1;
            end
            HPHA_HOLD:
            begin
                if (host_bus.cs_n || !(is_wr || is_rd))
                    st_nxt = HPHA_IDLE;
            end
            default:
                st_nxt = HPHA_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            st_r <= HPHA_IDLE;
            cnt_r <= 4'h0;
            prev_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            prev_r <= prev_nxt;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            acc_rd <= 1'b0;
            acc_wr <= 1'b0;
        end
        else
        begin
            acc_rd <= (st_nxt == HPHA_DONE) && is_rd;
            acc_wr <= (st_nxt == HPHA_DONE) && is_wr;
        end
    end

    // ----------------------------------------
    // shared pin drive
    // ----------------------------------------
    logic done_nxt;
    logic busy_nxt;

    assign done_nxt = (st_nxt == HPHA_DONE) || (st_nxt == HPHA_HOLD);
    assign busy_nxt = (st_nxt == HPHA_WAIT);

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            hs_o <= 1'b0;
            hs_oe <= 1'b0;
        end
        else if (ser_en)
        begin
            hs_o <= ser_o;
            hs_oe <= ser_oe;
        end
        else if (style_r == HPHA_STYLE_STROBE)
        begin
            hs_o <= ~done_nxt;
            hs_oe <= busy_nxt || done_nxt;
        end
        else
        begin
            hs_o <= done_nxt;
            hs_oe <= busy_nxt || done_nxt;
        end
    end
endmodule

/* hpha_top_checker.sv */
module hpha_top_checker
    import hpha_pkg::*;
#(
    parameter int NSRC = HPHA_NSRC
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // straps and host bus
    input wire logic bus_style_sel,
    input wire logic [1:0] port_mode,
    input wire hpha_pkg::hpha_bus_t host_bus,
    // interrupt sources
    input wire logic [NSRC-1:0] src_event,
    input wire logic [NSRC-1:0] src_enable,
    input wire logic [NSRC-1:0] src_clear,
    // outputs
    input wire logic [7:0] acc_addr,
    input wire logic irq_n_o,
    input wire logic irq_n_oe,
    input wire logic hs_o,
    input wire logic hs_oe
);
    // ------------------------------
    // pin rules
    // ------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    logic par, strb, rwen, act;
    assign par = port_mode == HPHA_MODE_PAR;
    assign strb = par && bus_style_sel == HPHA_STYLE_STROBE;
    assign rwen = par && bus_style_sel == HPHA_STYLE_RWEN;
    assign act = host_bus.rd || host_bus.wr;

    property p_low; irq_n_oe |-> !irq_n_o; endproperty
    a_low: assert property (p_low) else $error("irq high");
    property p_set; (|(src_event & src_enable)) ##1 (src_clear == '0 && $stable(src_enable)) [*2]
        |=> irq_n_oe; endproperty
    a_set: assert property (p_set) else $error("irq missing");
    property p_mask; (src_enable == '0) [*2] |=> !irq_n_oe; endproperty
    a_mask: assert property (p_mask) else $error("irq masked");
    property p_hold; irq_n_oe && $past(src_clear, 2) == '0
        && $past(src_enable) == $past(src_enable, 2) |=> irq_n_oe; endproperty
    a_hold: assert property (p_hold) else $error("irq dropped");
    property p_ack; strb && $fell(host_bus.cs_n) && act
        |=> hs_oe && hs_o ##1 hs_oe && !hs_o; endproperty
    a_ack: assert property (p_ack) else $error("ack timing");
    property p_stand; strb && hs_oe && !hs_o && !host_bus.cs_n && act
        |=> hs_oe && !hs_o; endproperty
    a_stand: assert property (p_stand) else $error("ack lost");
    property p_wait; strb && !host_bus.cs_n && !$past(host_bus.cs_n) && $rose(host_bus.wr)
        |=> (hs_oe && hs_o) [*3] ##1 (hs_oe && !hs_o); endproperty
    a_wait: assert property (p_wait) else $error("wait states");
    property p_rdy; rwen && $fell(host_bus.cs_n) && act
        |=> (hs_oe && !hs_o) [*2] ##1 (hs_oe && hs_o); endproperty
    a_rdy: assert property (p_rdy) else $error("ready timing");
    property p_rel; par && hs_oe && host_bus.cs_n |-> ##[1:2] !hs_oe; endproperty
    a_rel: assert property (p_rel) else $error("no release");
    property p_addr; par && $fell(host_bus.ale) |-> ##2 acc_addr == host_bus.ad; endproperty
    a_addr: assert property (p_addr) else $error("address");
    c_rmw: cover property (strb && !host_bus.cs_n && $rose(host_bus.wr));
    c_irq: cover property ($rose(irq_n_oe));
    c_ser: cover property (port_mode == HPHA_MODE_SER && hs_oe);
endmodule
bind hpha_top hpha_top_checker #(.NSRC(NSRC)) u_chk (.clk_sys(clk_sys), .resetn(resetn),
    .bus_style_sel(bus_style_sel), .port_mode(port_mode), .host_bus(host_bus),
    .src_event(src_event), .src_enable(src_enable), .src_clear(src_clear),
    .acc_addr(acc_addr), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .hs_o(hs_o), .hs_oe(hs_oe));

/* hpha_top_tb.sv */
module hpha_top_tb
    import hpha_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic bus_style_sel = 1'b0;
    logic [1:0] port_mode = HPHA_MODE_PAR;
    logic out_edge_sel = 1'b0;
    logic [HPHA_NSRC-1:0] src_event = '0, src_enable = '0, src_clear = '0, b;
    logic [7:0] rd_data = 8'h00, acc_addr, a, q;
    logic acc_rd, acc_wr, irq_n_o, irq_n_oe, hs_o, hs_oe, irq_pin, w, o;
    hpha_bus_t host_bus;
    int error_cnt = 0, checks_done = 0, seed = 32'h6125;
    logic [9:0] exp_q[$];

    always #50 clk_sys = ~clk_sys;
    assign irq_pin = irq_n_oe ? irq_n_o : 1'b1;
    hpha_top uut (.clk_sys(clk_sys), .resetn(resetn), .bus_style_sel(bus_style_sel),
        .port_mode(port_mode), .out_edge_sel(out_edge_sel), .host_bus(host_bus),
        .src_event(src_event), .src_enable(src_enable), .src_clear(src_clear),
        .rd_data(rd_data), .acc_addr(acc_addr), .acc_rd(acc_rd), .acc_wr(acc_wr),
        .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .hs_o(hs_o), .hs_oe(hs_oe));
    hpha_host_model host (.clk_sys(clk_sys), .bus_style_sel(bus_style_sel),
        .out_edge_sel(out_edge_sel), .hs_o(hs_o), .hs_oe(hs_oe), .bus(host_bus));

    // ------------------------------
    // checking
    // ------------------------------
    task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic close_out;
        if (error_cnt == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    always @(negedge clk_sys)
        if (resetn === 1'b1 && port_mode == HPHA_MODE_PAR && (acc_rd | acc_wr) === 1'b1)
            chk("acc", exp_q.size() ? exp_q.pop_front() : 10'h3FF,
                {acc_rd, acc_wr, acc_addr});
    initial
    begin
        #1000000;
        error_cnt++;
        close_out();
    end

    // ------------------------------
    // stimulus
    // ------------------------------
    initial
    begin
        tick(20);
        resetn = 1'b1;
        tick(2);
        for (int s = 0; s < 2; s++)
        begin
            bus_style_sel = s[0];
            tick(3);
            for (int i = 0; i < 6; i++)
            begin
                a = 8'($random(seed));
                w = 1'($random(seed));
                exp_q.push_back({!w, w, a});
                host.par(w, a, 1'b0);
            end
            exp_q.push_back({2'b10, a});
            exp_q.push_back({2'b01, a});
            host.par(1'b0, a, 1'b1);
            host.par(1'b1, a, 1'b0);
        end
        chk("left", 10'h000, 10'(exp_q.size()));
        for (int k = 0; k < 3; k++)
        begin
            b = '0;
            b[$unsigned($random(seed)) % HPHA_NSRC] = 1'b1;
            src_enable = b;
            src_event = b;
            tick(1);
            src_event = '0;
            tick(3);
            chk("irq", 10'h000, 10'(irq_pin));
            src_enable = '0;
            tick(3);
            chk("irq", 10'h001, 10'(irq_pin));
            src_enable = b;
            tick(3);
            chk("irq", 10'h000, 10'(irq_pin));
            src_clear = b;
            tick(1);
            src_clear = '0;
            tick(3);
            chk("irq", 10'h001, 10'(irq_pin));
            src_enable = ~b;
            src_event = b;
            tick(1);
            src_event = '0;
            tick(3);
            chk("irq", 10'h001, 10'(irq_pin));
            src_clear = b;
            tick(1);
            src_clear = '0;
        end
        port_mode = HPHA_MODE_SER;
        for (int s = 0; s < 2; s++)
        begin
            out_edge_sel = s[0];
            rd_data = 8'($random(seed));
            a = 8'($random(seed));
            tick(2);
            host.ser(1'b1, a[6:0], q, o);
            chk("ser_data", 10'(rd_data), 10'(q));
            chk("ser_oe", 10'h001, 10'(o));
            host.ser(1'b0, a[6:0], q, o);
            chk("ser_oe", 10'h000, 10'(o));
        end
        close_out();
    end
endmodule
